// ==== src/trim_cal_regs.sv ====
// per-channel termination trim and calibration register bank
module trim_cal_regs (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire trim_cal_pkg::reg_req_t i_req,
    input wire logic i_valid,
    output logic [trim_cal_pkg::DATA_W-1:0] o_rdata,
    output trim_cal_pkg::chan_trims_t o_trims [trim_cal_pkg::NUM_CH],
    output logic o_busy
);
    import trim_cal_pkg::*;

    // ****************************************
    // channel selector and decode
    // ****************************************
    logic [2:0] sel_q;
    logic sel_ok;
    logic [1:0] ch;
    logic wr;
    assign wr = i_valid & i_req.wr;
    assign sel_ok = (sel_q >= SEL_CH_FIRST) && (sel_q <= SEL_CH_LAST);
    assign ch = 2'(sel_q - SEL_CH_FIRST);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sel_q <= SEL_RESET;
        end else if (wr && i_req.addr == ADDR_CHAN_SEL) begin
            sel_q <= i_req.wdata[2:0];
        end
    end

    // ****************************************
    // transfer sequencer
    // ****************************************
    xfer_state_t st_q;
    logic [2:0] pend_q;   // skew, shift, scale
    logic [1:0] xch_q;
    logic [2:0] newreq;
    logic ctrl_wr;
    assign ctrl_wr = wr && sel_ok && i_req.addr == ADDR_CAL_CTRL;
    assign newreq[0] = i_req.wdata[SCALE_REQ_LSB +: 2] == REQ_TRANSFER;
    assign newreq[1] = i_req.wdata[SHIFT_REQ_LSB +: 2] == REQ_TRANSFER;
    assign newreq[2] = i_req.wdata[SKEW_REQ_LSB +: 2] == REQ_TRANSFER;

    // busy sequencer refuses new control writes for any channel until its sequence ends
    logic start;
    assign start = ctrl_wr && (st_q == XF_IDLE) && (newreq != 3'h0);

    function automatic xfer_state_t pick(input logic [2:0] p);
        if (p[0]) begin
            return XF_SCALE;
        end else if (p[1]) begin
            return XF_SHIFT;
        end else if (p[2]) begin
            return XF_SKEW;
        end
        return XF_IDLE;
    endfunction

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q <= XF_IDLE;
            pend_q <= 3'h0;
            xch_q <= 2'h0;
        end else if (start) begin
            st_q <= pick(newreq);
            pend_q <= newreq;
            xch_q <= ch;
        end else begin
            unique case (st_q)
                XF_IDLE: begin
                    st_q <= XF_IDLE;
                end
                XF_SCALE: begin
                    st_q <= pick({pend_q[2:1], 1'b0});
                    pend_q[0] <= 1'b0;
                end
                XF_SHIFT: begin
                    st_q <= pick({pend_q[2], 2'b00});
                    pend_q[1] <= 1'b0;
                end
                XF_SKEW: begin
                    st_q <= XF_IDLE;
                    pend_q[2] <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= start || (st_q != XF_IDLE && pick(pend_q) != st_q)
                      || (st_q == XF_SCALE && pend_q[2:1] != 2'b00)
                      || (st_q == XF_SHIFT && pend_q[2]);
        end
    end

    // ****************************************
    // per-channel storage
    // ****************************************
    chan_trims_t stg [NUM_CH];
    chan_trims_t act [NUM_CH];

    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        logic hit;
        logic mine;
        assign hit = wr && sel_ok && ch == 2'(g);
        assign mine = xch_q == 2'(g);

        always_ff @(posedge i_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
                stg[g].trim <= TRIM_RESET;
                stg[g].shift <= CODE_RESET;
                stg[g].scale <= CODE_RESET;
                stg[g].skew <= CODE_RESET;
            end else if (hit) begin
                unique case (i_req.addr)
                    ADDR_TERM_TRIM: stg[g].trim <= i_req.wdata[3:0];
                    ADDR_STG_SHIFT: stg[g].shift <= i_req.wdata[9:0];
                    ADDR_STG_SCALE: stg[g].scale <= i_req.wdata[9:0];
                    ADDR_STG_SKEW: stg[g].skew <= i_req.wdata[9:0];
                    default: begin
                    end
                endcase
            end
        end

        always_ff @(posedge i_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
                act[g].shift <= CODE_RESET;
                act[g].scale <= CODE_RESET;
                act[g].skew <= CODE_RESET;
            end else if (mine) begin
                if (st_q == XF_SCALE) begin
                    act[g].scale <= stg[g].scale;
                end
                if (st_q == XF_SHIFT) begin
                    act[g].shift <= stg[g].shift;
                end
                if (st_q == XF_SKEW) begin
                    act[g].skew <= stg[g].skew;
                end
            end
        end
        assign act[g].trim = stg[g].trim;

        // codes drive the analog trims unchanged; meaning is monotone
        always_ff @(posedge i_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
                o_trims[g] <= {CODE_RESET, CODE_RESET, CODE_RESET,
                               TRIM_RESET};
            end else begin
                o_trims[g] <= act[g];
            end
        end
    end

    // ****************************************
    // read path
    // ****************************************
    logic [DATA_W-1:0] rd_d;
    always_comb begin
        rd_d = 16'h0000;
        if (i_req.addr == ADDR_CHAN_SEL) begin
            rd_d = {13'h0000, sel_q};
        end else if (sel_ok) begin
            unique case (i_req.addr)
                ADDR_MAILBOX: rd_d[BUSY_BIT] = o_busy;
                ADDR_TERM_TRIM: rd_d = {12'h000, stg[ch].trim};
                ADDR_STG_SHIFT: rd_d = {6'h00, stg[ch].shift};
                ADDR_ACT_SHIFT: rd_d = {6'h00, act[ch].shift};
                ADDR_STG_SCALE: rd_d = {6'h00, stg[ch].scale};
                ADDR_ACT_SCALE: rd_d = {6'h00, act[ch].scale};
                ADDR_STG_SKEW: rd_d = {6'h00, stg[ch].skew};
                ADDR_ACT_SKEW: rd_d = {6'h00, act[ch].skew};
                default: rd_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 16'h0000;
        end else if (i_valid && !i_req.wr) begin
            o_rdata <= rd_d;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    scale_first_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        start && newreq[0] |=> st_q == XF_SCALE)
        else $error("scale transfer not first");
    skew_last_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        start && newreq == 3'h7 |=> ##1 st_q == XF_SHIFT ##1 st_q == XF_SKEW)
        else $error("transfer order wrong");
    busy_set_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        start |=> o_busy)
        else $error("busy not raised");
    busy_clear_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        start |-> ##[1:4] !o_busy)
        else $error("busy never cleared");
    act_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        st_q == XF_IDLE |=> $stable(act[0].shift))
        else $error("level shift moved without transfer");
    scale_copy_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        st_q == XF_SCALE && xch_q == 2'h1
        |=> act[1].scale == $past(stg[1].scale))
        else $error("scale not copied");
    skew_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        st_q != XF_SKEW |=> $stable(act[2].skew))
        else $error("skew moved without transfer");
    sel_gate_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        wr && !sel_ok && i_req.addr == ADDR_TERM_TRIM |=> $stable(stg[3].trim))
        else $error("write reached channel with no selection");
    shift_copy_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        st_q == XF_SHIFT && xch_q == 2'h0
        |=> act[0].shift == $past(stg[0].shift))
        else $error("level shift not copied");
    skew_copy_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        st_q == XF_SKEW && xch_q == 2'h3
        |=> act[3].skew == $past(stg[3].skew))
        else $error("skew not copied");
    scale_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        st_q != XF_SCALE |=> $stable(act[1].scale))
        else $error("scale moved without transfer");
    shift_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        st_q != XF_SHIFT |=> $stable(act[3].shift))
        else $error("level shift moved without transfer");
    busy_idle_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        !start && st_q == XF_IDLE |=> !o_busy)
        else $error("busy high while idle");
    busy_run_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        st_q == XF_SCALE && pend_q[2] |=> o_busy)
        else $error("busy dropped with work pending");
    busy_refuse_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        ctrl_wr && st_q != XF_IDLE |=> $stable(xch_q))
        else $error("control write taken while busy");
    order_skip_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        start && newreq == 3'h5 |=> st_q == XF_SCALE ##1 st_q == XF_SKEW)
        else $error("scale then skew order wrong");
    trim_write_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        wr && sel_ok && ch == 2'h0 && i_req.addr == ADDR_TERM_TRIM
        |=> stg[0].trim == $past(i_req.wdata[3:0]))
        else $error("trim write not stored");
    trim_out_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_reset_n |=> o_trims[2].trim == $past(stg[2].trim))
        else $error("trim output not following register");
    scale_out_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_reset_n |=> o_trims[1].scale == $past(act[1].scale))
        else $error("scale output not following register");
    unused_zero_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_valid && !i_req.wr |=> o_rdata[15:10] == 6'h00)
        else $error("unused read bits not zero");
    nosel_read_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_valid && !i_req.wr && !sel_ok && i_req.addr != ADDR_CHAN_SEL
        |=> o_rdata == 16'h0000)
        else $error("read with no channel not zero");
    sel_read_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_valid && !i_req.wr && i_req.addr == ADDR_CHAN_SEL
        |=> o_rdata[2:0] == $past(sel_q))
        else $error("selector read wrong");
    act_read_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_valid && !i_req.wr && sel_ok && i_req.addr == ADDR_ACT_SCALE
        |=> o_rdata[9:0] == $past(act[ch].scale))
        else $error("active scale read wrong");
    mbox_read_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_valid && !i_req.wr && sel_ok && i_req.addr == ADDR_MAILBOX
        |=> o_rdata[0] == $past(o_busy))
        else $error("mailbox busy read wrong");
endmodule

// ==== shared/trim_cal_pkg.sv ====
// package: register map, field layout, resets and carrier types
package trim_cal_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 16;
    localparam int CODE_W = 10;
    localparam int TRIM_W = 4;
    localparam int NUM_CH = 4;
    localparam logic [6:0] ADDR_CHAN_SEL = 7'h0F;
    localparam logic [6:0] ADDR_CAL_CTRL = 7'h10;
    localparam logic [6:0] ADDR_MAILBOX = 7'h11;
    localparam logic [6:0] ADDR_TERM_TRIM = 7'h13;
    localparam logic [6:0] ADDR_STG_SHIFT = 7'h20;
    localparam logic [6:0] ADDR_ACT_SHIFT = 7'h21;
    localparam logic [6:0] ADDR_STG_SCALE = 7'h22;
    localparam logic [6:0] ADDR_ACT_SCALE = 7'h23;
    localparam logic [6:0] ADDR_STG_SKEW = 7'h24;
    localparam logic [6:0] ADDR_ACT_SKEW = 7'h25;
    localparam logic [3:0] TRIM_RESET = 4'h7;
    localparam logic [9:0] CODE_RESET = 10'h200;
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic [2:0] SEL_CH_FIRST = 3'h1;
    localparam logic [2:0] SEL_CH_LAST = 3'h4;
    localparam logic [1:0] REQ_TRANSFER = 2'h2;
    localparam int SHIFT_REQ_LSB = 2;
    localparam int SCALE_REQ_LSB = 4;
    localparam int SKEW_REQ_LSB = 6;
    localparam int BUSY_BIT = 0;

    typedef enum logic [1:0] {
        XF_IDLE = 2'b00,
        XF_SCALE = 2'b01,
        XF_SHIFT = 2'b10,
        XF_SKEW = 2'b11
    } xfer_state_t;

    typedef struct packed {
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [CODE_W-1:0] shift;
        logic [CODE_W-1:0] scale;
        logic [CODE_W-1:0] skew;
        logic [TRIM_W-1:0] trim;
    } chan_trims_t;
endpackage

// ==== dv/spi_host_model.sv ====
// host model issuing deframed register words to the bank
module spi_host_model (
    input wire logic i_clk,
    input wire logic [trim_cal_pkg::DATA_W-1:0] i_rdata,
    output trim_cal_pkg::reg_req_t o_req,
    output logic o_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    import trim_cal_pkg::*;
    initial begin
        o_req = '0;
        o_valid = 1'b0;
    end
    // one word per call, driven and released on falling edges
    task automatic access(input logic wr, input logic [6:0] a,
                          input logic [15:0] d, output logic [15:0] q);
        @(negedge i_clk);
        o_req <= '{wr: wr, addr: a, wdata: d};
        o_valid <= 1'b1;
        @(negedge i_clk);
        o_valid <= 1'b0;
        o_req.wdata <= ~d;
        q = i_rdata;
    endtask
    // selector written before any per-channel access
    task automatic select(input logic [2:0] s);
        logic [15:0] q;
        access(1'b1, ADDR_CHAN_SEL, {13'h0, s}, q);
    endtask
endmodule

// ==== dv/per_channel_trim_cal_regs_bench.sv ====
// self-checking bench for the trim and calibration bank
module per_channel_trim_cal_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import trim_cal_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    reg_req_t req;
    logic valid, o_busy;
    logic [15:0] o_rdata;
    chan_trims_t o_trims [NUM_CH];
    logic [9:0] stg [4][3];
    logic [9:0] act [4][3];
    logic [3:0] trm [4];
    logic [2:0] sel;
    int fails = 0;
    int cmp_count = 0;
    int seed = 85;
    logic [6:0] rd_list [10] = '{7'h0F, 7'h11, 7'h13, 7'h20, 7'h21,
        7'h22, 7'h23, 7'h24, 7'h25, 7'h30};
    logic [6:0] wr_list [8] = '{7'h13, 7'h20, 7'h21, 7'h22, 7'h23,
        7'h24, 7'h25, 7'h10};
    always #5 i_clk = ~i_clk;
    trim_cal_regs dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(req),
        .i_valid(valid), .o_rdata(o_rdata), .o_trims(o_trims),
        .o_busy(o_busy));
    spi_host_model host (.i_clk(i_clk), .i_rdata(o_rdata), .o_req(req),
        .o_valid(valid));
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] expect_rd(input logic [6:0] a);
        int c;
        c = int'(sel) - 1;
        if (a == ADDR_CHAN_SEL) return {13'h0, sel};
        if (c < 0 || c > 3) return 16'h0000;
        case (a)
            ADDR_TERM_TRIM: return {12'h000, trm[c]};
            ADDR_STG_SHIFT: return {6'h00, stg[c][0]};
            ADDR_ACT_SHIFT: return {6'h00, act[c][0]};
            ADDR_STG_SCALE: return {6'h00, stg[c][1]};
            ADDR_ACT_SCALE: return {6'h00, act[c][1]};
            ADDR_STG_SKEW: return {6'h00, stg[c][2]};
            ADDR_ACT_SKEW: return {6'h00, act[c][2]};
            default: return 16'h0000;
        endcase
    endfunction
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] q;
        logic any;
        int c;
        int n;
        c = int'(sel) - 1;
        any = 1'b0;
        host.access(1'b1, a, d, q);
        if (a == ADDR_CHAN_SEL) sel = d[2:0];
        else if (c >= 0 && c <= 3) begin
            case (a)
                ADDR_TERM_TRIM: trm[c] = d[3:0];
                ADDR_STG_SHIFT: stg[c][0] = d[9:0];
                ADDR_STG_SCALE: stg[c][1] = d[9:0];
                ADDR_STG_SKEW: stg[c][2] = d[9:0];
                default: ;
            endcase
            // fields at 3:2 shift, 5:4 scale, 7:6 skew
            for (int k = 0; k < 3; k++) begin
                if (a == ADDR_CAL_CTRL && d[2+2*k +: 2] == 2'h2) begin
                    act[c][k] = stg[c][k];
                    any = 1'b1;
                end
            end
        end
        chk(o_busy, any);
        n = 0;
        while (o_busy === 1'b1 && n < 8) begin
            @(negedge i_clk);
            n++;
        end
        if (n == 8) begin
            fails++;
            print_verdict();
        end
    endtask
    task automatic check_all();
        logic [15:0] q;
        for (int s = 0; s < 8; s++) begin
            host.select(3'(s));
            sel = 3'(s);
            foreach (rd_list[i]) begin
                host.access(1'b0, rd_list[i], 16'hFFFF, q);
                chk(q, expect_rd(rd_list[i]));
            end
        end
        for (int c = 0; c < 4; c++)
            chk(o_trims[c], {act[c][0], act[c][1], act[c][2], trm[c]});
    endtask
    initial begin
        sel = 3'h0;
        for (int c = 0; c < 4; c++) begin
            trm[c] = 4'h7;
            for (int k = 0; k < 3; k++) begin
                stg[c][k] = 10'h200;
                act[c][k] = 10'h200;
            end
        end
        repeat (3) @(negedge i_clk);
        i_reset_n = 1'b1;
        check_all();
        for (int s = 1; s < 5; s++) begin
            wr(ADDR_CHAN_SEL, 16'(s));
            wr(ADDR_STG_SHIFT, 16'hFC00 | 16'(s));
            wr(ADDR_STG_SCALE, 16'h03FF);
            wr(ADDR_STG_SKEW, 16'h0000);
            wr(ADDR_CAL_CTRL, 16'h00A8);
        end
        check_all();
        repeat (60) begin
            if ($random(seed) % 3 == 0) wr(ADDR_CHAN_SEL, 16'($random(seed)));
            wr(wr_list[3'($random(seed))], 16'($random(seed)));
            check_all();
        end
        print_verdict();
    end
endmodule
